/* design/esm_monitor.sv */
// Emergency-stop safety monitor with diagnostic status over AXI4-Lite
// Field inputs are taken as already synchronous to aclk.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module esm_monitor #(
  parameter int ADDR_W = 8,
  parameter int SKEW_CYCLES = int'(esm_pkg::SKEW_CYCLES)
) (
  input wire logic aclk, // Sampling clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [esm_pkg::NUM_STOPS-1:0] chan_pos, // Positive channels, 1 = closed
  input wire logic [esm_pkg::NUM_STOPS-1:0] chan_neg, // Negative channels, 1 = closed
  input wire logic contact_type_select, // 1 = dual contacts, 0 = single
  input wire logic reactivation_input, // 1 = request present
  input wire logic reactivation_monitor_strap, // 1 = strap closed
  input wire logic feedback_loop_input, // 1 = loop closed
  input wire logic safety_supply_ok, // Safety system supply present
  input wire logic ext_supply_ok, // External module supply present
  input wire logic ext_supply_monitor_strap, // 1 = supply loss is monitored
  output logic safety_output_one, // First safety output, 1 = closed
  output logic safety_output_two, // Second safety output, 1 = closed
  output logic irq, // Level interrupt
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  // Short local names for the common widths
  localparam int N = esm_pkg::NUM_STOPS;
  localparam int IW = esm_pkg::IRQ_W;

  // All state of the monitor except the skew timer in one register
  typedef struct packed {
    logic out;
    logic react_prev;
    logic skew_flt;
    logic supply_bad;
    logic [N-1:0] pend;
    logic [IW-1:0] irq_stat;
    logic [IW-1:0] irq_mask;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } esm_state_t;

  // Current and next state
  esm_state_t q;
  esm_state_t d;

  // Address decode shared by read and write paths
  function automatic esm_pkg::esm_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    if (addr[1:0] != 2'h0) begin
      reg_sel = esm_pkg::SEL_NONE;
    end else if (a == esm_pkg::OFS_STATUS) begin
      reg_sel = esm_pkg::SEL_STATUS;
    end else if (a == esm_pkg::OFS_IRQ_STATUS) begin
      reg_sel = esm_pkg::SEL_IRQ_STATUS;
    end else if (a == esm_pkg::OFS_IRQ_MASK) begin
      reg_sel = esm_pkg::SEL_IRQ_MASK;
    end else if (a == esm_pkg::OFS_PAIR_FAULT) begin
      reg_sel = esm_pkg::SEL_PAIR_FAULT;
    end else begin
      reg_sel = esm_pkg::SEL_NONE;
    end
  endfunction : reg_sel

  // Channel decode and aggregates
  logic dual;
  logic [N-1:0] neg_eff;
  logic [N-1:0] pair_mis;
  logic [N-1:0] pair_open;
  logic [N-1:0] pend_set;
  logic pos_all;
  logic neg_all;
  logic auto_mode;
  logic skew_expired;

  // single contacts shunt the whole negative pole
  assign dual = contact_type_select;
  assign neg_eff = dual ? chan_neg : {N{1'b1}};

  generate
    for (genvar gi = 0; gi < N; gi++) begin : g_pair
      assign pair_mis[gi] = dual & (chan_pos[gi] ^ chan_neg[gi]);
      assign pair_open[gi] = ~chan_pos[gi] & ~neg_eff[gi];
      // skew in automatic mode is timed, not latched
      assign pend_set[gi] = ~auto_mode & pair_mis[gi];
    end
  endgenerate

  assign pos_all = &chan_pos;
  assign neg_all = &neg_eff;
  // both straps shunted means automatic start-up
  assign auto_mode = reactivation_monitor_strap & reactivation_input;

  esm_skew_timer #(
    .CYCLES(SKEW_CYCLES)
  ) u_skew (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(auto_mode),
    .pos_closed(pos_all),
    .neg_closed(neg_all),
    .expired(skew_expired)
  );

  // Status, control and bus decode
  logic [31:0] status_word;
  logic stop_req;
  logic permit;
  logic trigger;
  logic [IW-1:0] events;
  logic wr_go;
  logic rd_go;
  esm_pkg::esm_sel_t wsel;
  esm_pkg::esm_sel_t rsel;

  // diagnostic word; low 26 bits are the discrete inputs
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[esm_pkg::ST_POS_LSB +: N] = chan_pos;
    status_word[esm_pkg::ST_NEG_LSB +: N] = chan_neg;
    status_word[esm_pkg::ST_REACT] = reactivation_input;
    status_word[esm_pkg::ST_FEEDBACK] = feedback_loop_input;
    status_word[esm_pkg::ST_OUTPUT] = q.out;
    status_word[esm_pkg::ST_SAFE_SUPPLY] = safety_supply_ok;
    status_word[esm_pkg::ST_EXT_SUPPLY] = ext_supply_ok;
    status_word[esm_pkg::ST_SKEW_FAULT] = q.skew_flt;
    status_word[esm_pkg::ST_PAIR_FAULT] = |q.pend;
  end

  // any open contact or monitored supply loss forces a stop
  assign stop_req = ~(pos_all & neg_all) | ~safety_supply_ok
    | (ext_supply_monitor_strap & ~ext_supply_ok);

  // feedback loop closed and every pair self-checked
  assign permit = ~stop_req & feedback_loop_input & ~(|q.pend) & ~q.skew_flt & ~skew_expired;

  // edge or state start depending on strap
  assign trigger = reactivation_monitor_strap ? reactivation_input
    : (q.react_prev & ~reactivation_input);

  // AXI handshakes: write needs address and data together
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
  assign rd_go = s_axi_arvalid & ~q.rvalid;
  // One decoder serves both address channels
  assign wsel = reg_sel(s_axi_awaddr);
  assign rsel = reg_sel(s_axi_araddr);

  always_comb begin
    d = q;
    d.react_prev = reactivation_input;
    // outputs depend only on field inputs, never on bus writes
    if (stop_req) begin
      d.out = 1'b0;
    // close only on a valid reactivation
    end else if (!q.out && permit && trigger) begin
      d.out = 1'b1;
    end
    // mismatch pending until both channels opened
    if (!dual) begin
      d.pend = '0;
    end else begin
      // Automatic mode leaves channel skew to the window timer, so a
      // channel that recloses inside the window is not latched here
      d.pend = (q.pend | pend_set) & ~pair_open;
    end
    // latched skew fault, cleared once both poles have an open channel
    if (skew_expired) begin
      d.skew_flt = 1'b1;
    end else if (!pos_all && !neg_all) begin
      d.skew_flt = 1'b0;
    end
    // Supply fault level, kept for its rising edge
    d.supply_bad = ~safety_supply_ok | (ext_supply_monitor_strap & ~ext_supply_ok);
    // Events for the sticky interrupt status
    events = '0;
    events[esm_pkg::EV_OPENED] = q.out & ~d.out;
    events[esm_pkg::EV_CLOSED] = ~q.out & d.out;
    events[esm_pkg::EV_SKEW] = skew_expired & ~q.skew_flt;
    events[esm_pkg::EV_MISMATCH] = |(pend_set & ~q.pend);
    events[esm_pkg::EV_SUPPLY] = d.supply_bad & ~q.supply_bad;
    // Write path; the set of a new event wins over a one-to-clear
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    d.irq_stat = q.irq_stat;
    if (wr_go) begin
      d.bvalid = 1'b1;
      d.bresp = esm_pkg::RESP_OKAY;
      // Only byte lane 0 carries register bits
      case (wsel)
        esm_pkg::SEL_IRQ_STATUS: begin
          if (s_axi_wstrb[0]) begin
            d.irq_stat = q.irq_stat & ~s_axi_wdata[IW-1:0];
          end
        end
        esm_pkg::SEL_IRQ_MASK: begin
          if (s_axi_wstrb[0]) begin
            d.irq_mask = s_axi_wdata[IW-1:0];
          end
        end
        esm_pkg::SEL_STATUS, esm_pkg::SEL_PAIR_FAULT: begin
          d.bresp = esm_pkg::RESP_OKAY; // Read-only, write ignored
        end
        default: begin
          d.bresp = esm_pkg::RESP_SLVERR;
        end
      endcase
    end
    d.irq_stat = d.irq_stat | events;
    // read path returns live diagnostics, one cycle after the address
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rresp = esm_pkg::RESP_OKAY;
      // Unmapped offsets read as zero with an error response
      case (rsel)
        esm_pkg::SEL_STATUS: d.rdata = status_word;
        esm_pkg::SEL_IRQ_STATUS: d.rdata = {{(32-IW){1'b0}}, q.irq_stat};
        esm_pkg::SEL_IRQ_MASK: d.rdata = {{(32-IW){1'b0}}, q.irq_mask};
        esm_pkg::SEL_PAIR_FAULT: d.rdata = {{(32-N){1'b0}}, q.pend};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = esm_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.irq_mask <= esm_pkg::IRQ_MASK_RST;
    end else begin
      q <= d;
    end
  end

  // both outputs follow one control flop
  assign safety_output_one = q.out;
  assign safety_output_two = q.out;

  // Level interrupt from unmasked sticky bits
  assign irq = |(q.irq_stat & q.irq_mask);

  // Bus handshakes; write ready only with a full request present
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
endmodule : esm_monitor

/* design/esm_pkg.sv */
// Shared constants for the emergency-stop safety monitor
package esm_pkg;
  // Stop inputs and channel layout
  localparam int NUM_STOPS = 12;
  // Sampling clock and channel-skew window
  localparam longint unsigned CLK_HZ = 64'd20_000_000;
  localparam longint unsigned SKEW_MS = 64'd400;
  localparam longint unsigned SKEW_CYCLES = (SKEW_MS * CLK_HZ) / 64'd1000;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_PAIR_FAULT = 8'h0C;
  // Status word fields
  localparam int ST_POS_LSB = 0;
  localparam int ST_NEG_LSB = 12;
  localparam int ST_REACT = 24;
  localparam int ST_FEEDBACK = 25;
  localparam int ST_OUTPUT = 26;
  localparam int ST_SAFE_SUPPLY = 27;
  localparam int ST_EXT_SUPPLY = 28;
  localparam int ST_SKEW_FAULT = 29;
  localparam int ST_PAIR_FAULT = 30;
  // Interrupt event bits
  localparam int IRQ_W = 5;
  localparam int EV_OPENED = 0;
  localparam int EV_CLOSED = 1;
  localparam int EV_SKEW = 2;
  localparam int EV_MISMATCH = 3;
  localparam int EV_SUPPLY = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register selector
  typedef enum {SEL_STATUS, SEL_IRQ_STATUS, SEL_IRQ_MASK, SEL_PAIR_FAULT, SEL_NONE} esm_sel_t;
endpackage : esm_pkg

/* design/esm_skew_timer.sv */
// Channel-skew window timer for automatic start-up
`timescale 1ns/1ps
module esm_skew_timer #(
  parameter int CYCLES = 8000000
) (
  input wire logic aclk, // Sampling clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic enable, // Automatic start-up mode
  input wire logic pos_closed, // All positive channels closed
  input wire logic neg_closed, // All negative channels closed
  output logic expired // Skew longer than the window
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LIMIT = W'(CYCLES);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic expired;
  } esm_tmr_t;

  esm_tmr_t q;
  esm_tmr_t d;

  // Count only while the two channels disagree
  always_comb begin
    d = q;
    if (!enable || (pos_closed == neg_closed)) begin
      d.cnt = '0;
      d.expired = 1'b0;
    end else if (q.cnt == LIMIT) begin
      d.expired = 1'b1; // Held until channels agree again or enable drops
    end else begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;
endmodule : esm_skew_timer

/* verification/esm_feedback_model.sv */
// Relay feedback loop model on the far side of the safety outputs
`timescale 1ns/1ps
module esm_feedback_model (
  input wire logic safety_output_one, // First output, 1 = closed
  input wire logic safety_output_two, // Second output, 1 = closed
  input wire logic host_permit, // Host series contact, 1 = closed
  output logic feedback_loop_input // Loop level seen by the monitor
);
  // relays in loop, host series contact
  // Loop reads closed only with both relays dropped and the host contact made
  assign feedback_loop_input = !(safety_output_one || safety_output_two) && host_permit;
endmodule : esm_feedback_model

/* verification/esm_monitor_assertions.sv */
// Concurrent checks on the safety monitor ports
`timescale 1ns/1ps
module esm_monitor_assertions (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic [11:0] chan_pos, // Positive channels
  input wire logic [11:0] chan_neg, // Negative channels
  input wire logic contact_type_select, // Contact type
  input wire logic reactivation_input, // Restart request
  input wire logic reactivation_monitor_strap, // Start mode
  input wire logic feedback_loop_input, // Feedback loop
  input wire logic safety_supply_ok, // Safety supply
  input wire logic ext_supply_ok, // External supply
  input wire logic ext_supply_monitor_strap, // Supply monitor
  input wire logic safety_output_one, // Output one
  input wire logic safety_output_two // Output two
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Outputs and their causes
  outs_equal_a: assert property (safety_output_one == safety_output_two)
    else $error("safety outputs differ");
  stop_opens_a: assert property (!(&chan_pos) |=> !safety_output_one)
    else $error("open positive channel left outputs closed");
  neg_opens_a: assert property (contact_type_select && !(&chan_neg) |=> !safety_output_two)
    else $error("open negative channel left outputs closed");
  supply_opens_a: assert property (!safety_supply_ok || (!ext_supply_ok && ext_supply_monitor_strap)
    |=> !safety_output_one)
    else $error("supply loss left outputs closed");
  close_fb_a: assert property ($rose(safety_output_one) |-> $past(feedback_loop_input))
    else $error("outputs closed with feedback open");
  edge_start_a: assert property ($rose(safety_output_one) && !$past(reactivation_monitor_strap)
    |-> $past(reactivation_input, 2) && !$past(reactivation_input))
    else $error("edge mode closed without falling edge");
  level_start_a: assert property ($rose(safety_output_one) && $past(reactivation_monitor_strap)
    |-> $past(reactivation_input))
    else $error("level mode closed without request");
  reset_open_a: assert property ($rose(aresetn) |-> !safety_output_one ##1 !safety_output_one)
    else $error("outputs closed right after reset");
  // Main scenarios
  close_c: cover property ($rose(safety_output_one));
  stop_c: cover property ($fell(safety_output_one));
  auto_c: cover property ($rose(safety_output_one) && reactivation_monitor_strap);
endmodule : esm_monitor_assertions
bind esm_monitor esm_monitor_assertions chk_u (.*);

/* verification/esm_monitor_tb.sv */
// Self-checking bench for the safety monitor
`timescale 1ns/1ps
module esm_monitor_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] chan_pos = 12'hFFF, chan_neg = 12'hFFF;
  logic contact_type_select = 1'b1, reactivation_input = 1'b0, reactivation_monitor_strap = 1'b0;
  logic feedback_loop_input, safety_supply_ok = 1'b1, ext_supply_ok = 1'b1;
  logic ext_supply_monitor_strap = 1'b1, host_permit = 1'b1;
  logic safety_output_one, safety_output_two, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fail_count = 0, check_count = 0;
  esm_monitor #(.SKEW_CYCLES(20)) dut_u (.*);
  esm_feedback_model fb_u (.*);
  // Clock at 50 ns period
  initial forever #25 aclk = ~aclk;
  task test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  task ck(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : ck
  task co(input logic e);
    ck({31'h0, safety_output_one}, {31'h0, e});
  endtask : co
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // Bounded wait; a hang ends the run
  task lim(input int n);
    if (n >= 99) begin
      fail_count++;
      test_done();
    end
  endtask : lim
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_axi_awready !== 1'b1 && n < 99);
    lim(n);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 99);
    lim(n);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 99);
    lim(n);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 99);
    lim(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // Press and release of the restart button
  task pulse;
    reactivation_input <= 1'b1;
    cyc(3);
    reactivation_input <= 1'b0;
    cyc(3);
  endtask : pulse
  initial begin
    cyc(5);
    aresetn <= 1'b1;
    cyc(2);
    co(1'b0);
    rd(esm_pkg::OFS_STATUS);
    ck(d, 32'h1AFFFFFF);
    rd(esm_pkg::OFS_IRQ_MASK);
    ck(d, 32'h0);
    wr(esm_pkg::OFS_IRQ_MASK, 32'h1);
    wr(esm_pkg::OFS_STATUS, 32'hFFFFFFFF);
    ck({30'h0, r}, {30'h0, esm_pkg::RESP_OKAY});
    co(1'b0);
    // Held button must not start in edge mode
    reactivation_input <= 1'b1;
    cyc(4);
    co(1'b0);
    reactivation_input <= 1'b0;
    cyc(3);
    co(1'b1);
    rd(esm_pkg::OFS_STATUS);
    ck({31'h0, d[esm_pkg::ST_OUTPUT]}, 32'h1);
    // One channel opens: stop, pair fault until both seen open
    chan_pos[3] <= 1'b0;
    cyc(2);
    co(1'b0);
    ck({31'h0, irq}, 32'h1);
    rd(esm_pkg::OFS_PAIR_FAULT);
    ck(d, 32'h8);
    chan_pos[3] <= 1'b1;
    pulse();
    co(1'b0);
    // Both channels open together clears the pending pair
    chan_pos[3] <= 1'b0;
    chan_neg[3] <= 1'b0;
    cyc(2);
    chan_pos[3] <= 1'b1;
    chan_neg[3] <= 1'b1;
    pulse();
    co(1'b1);
    wr(esm_pkg::OFS_IRQ_STATUS, 32'h1F);
    ck({31'h0, irq}, 32'h0);
    // External supply loss, ignored then monitored
    ext_supply_monitor_strap <= 1'b0;
    ext_supply_ok <= 1'b0;
    cyc(3);
    co(1'b1);
    ext_supply_monitor_strap <= 1'b1;
    cyc(2);
    co(1'b0);
    ext_supply_ok <= 1'b1;
    host_permit <= 1'b0;
    pulse();
    co(1'b0);
    host_permit <= 1'b1;
    // Level start, then automatic start with skew
    reactivation_monitor_strap <= 1'b1;
    reactivation_input <= 1'b1;
    cyc(3);
    co(1'b1);
    chan_pos <= 12'h000;
    chan_neg <= 12'h000;
    cyc(3);
    chan_pos <= 12'hFFF;
    cyc(30);
    chan_neg <= 12'hFFF;
    cyc(3);
    co(1'b0);
    rd(esm_pkg::OFS_STATUS);
    ck({31'h0, d[esm_pkg::ST_SKEW_FAULT]}, 32'h1);
    chan_pos <= 12'h000;
    chan_neg <= 12'h000;
    cyc(3);
    chan_pos <= 12'hFFF;
    cyc(15);
    chan_neg <= 12'hFFF;
    cyc(3);
    co(1'b1);
    // Single contacts ignore the negative pole
    reactivation_monitor_strap <= 1'b0;
    reactivation_input <= 1'b0;
    chan_pos <= 12'h000;
    cyc(2);
    contact_type_select <= 1'b0;
    chan_neg <= 12'h000;
    chan_pos <= 12'hFFF;
    pulse();
    co(1'b1);
    // Safety supply loss always opens the outputs
    safety_supply_ok <= 1'b0;
    cyc(2);
    co(1'b0);
    safety_supply_ok <= 1'b1;
    // Reset in mid-run leaves the outputs open
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    co(1'b0);
    rd(8'h10);
    ck({30'h0, r}, {30'h0, esm_pkg::RESP_SLVERR});
    wr(8'h10, 32'h1);
    ck({30'h0, r}, {30'h0, esm_pkg::RESP_SLVERR});
    test_done();
  end
endmodule : esm_monitor_tb
